// ### rtl/sgc_top.sv
// Pin configuration registers and pin control for both serializer ports
`timescale 1ns/100ps
module sgc_top
    import sgc_pkg::*;
#(
    parameter logic [3:0] REVISION = SGC_REVISION_DFLT // Arbitrary value
) (
    input  wire logic                              I_SYS_CLK,
    input  wire logic                              I_NRST,
    input  wire logic [SGC_AW-1:0]                 I_ADDR,
    input  wire logic [SGC_DW-1:0]                 I_WDATA,
    input  wire logic                              I_WR,
    input  wire logic                              I_RD,
    output logic      [SGC_DW-1:0]                 O_RDATA,
    input  wire logic [SGC_PORTS*SGC_PINS-1:0]     I_REMOTE_VAL,
    input  wire logic [SGC_PORTS-1:0]              I_LINK_LOST,
    input  wire logic [SGC_PORTS*SGC_PINS-1:0]     I_PIN,
    output logic      [SGC_PORTS*SGC_PINS-1:0]     O_PIN,
    output logic      [SGC_PORTS*SGC_PINS-1:0]     O_PIN_OE,
    output logic      [SGC_PORTS*SGC_PINS-1:0]     O_FUNC_IN
);

    localparam int NPIN = SGC_PORTS * SGC_PINS;

    sgc_pin_cfg_s             cfg_reg [NPIN];
    logic                     second_port_select_reg;
    logic [SGC_DW-1:0]        rdata_next;
    logic [NPIN-1:0]          level;
    logic [NPIN-1:0]          pin_o;
    logic [NPIN-1:0]          pin_oe;
    logic [NPIN-1:0]          func_in;
    logic [2:0]               base;
    logic                     wr_pin0;
    logic                     wr_pin12;

    // Index of the selected port's first pin
    // Wide enough that base plus two never wraps for the second port
    assign base     = second_port_select_reg ? 3'(SGC_PINS) : 3'h0;
    assign wr_pin0  = I_WR && (I_ADDR == SGC_OFS_PIN0);
    assign wr_pin12 = I_WR && (I_ADDR == SGC_OFS_PIN12);

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            second_port_select_reg <= SGC_PORT_SEL_RST;
        end else if (I_WR && (I_ADDR == SGC_OFS_PORT_SEL)) begin
            second_port_select_reg <= I_WDATA[SGC_PORT_SEL_BIT];
        end
    end

    // Configuration storage, one field per pin of each port
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            for (int i = 0; i < NPIN; i++) begin
                cfg_reg[i] <= sgc_pin_cfg_s'(SGC_CFG_RST);
            end
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (wr_pin0 && (i == int'(base))) begin
                    cfg_reg[i] <= I_WDATA[SGC_LO_FIELD_LSB +: SGC_FIELD_W];
                end
                if (wr_pin12 && (i == int'(base) + 1)) begin
                    cfg_reg[i] <= I_WDATA[SGC_LO_FIELD_LSB +: SGC_FIELD_W];
                end
                if (wr_pin12 && (i == int'(base) + 2)) begin
                    cfg_reg[i] <= I_WDATA[SGC_HI_FIELD_LSB +: SGC_FIELD_W];
                end
            end
        end
    end

    // Read mux; unmapped addresses answer zero
    always_comb begin
        rdata_next = '0;
        unique case (I_ADDR)
            SGC_OFS_PIN0: begin
                rdata_next = {REVISION, cfg_reg[base]};
            end
            SGC_OFS_PIN12: begin
                rdata_next = {cfg_reg[base + 3'h2], cfg_reg[base + 3'h1]};
            end
            SGC_OFS_PORT_SEL: begin
                rdata_next[SGC_PORT_SEL_BIT] = second_port_select_reg;
            end
            SGC_OFS_PIN_LEVEL: begin
                rdata_next[SGC_PINS-1:0] = level[base +: SGC_PINS];
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            O_RDATA <= '0;
        end else if (I_RD) begin
            O_RDATA <= rdata_next;
        end else begin
            O_RDATA <= '0;
        end
    end

    // Each pin follows the link state of the port it belongs to
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        sgc_pin u_pin (
            .i_clk        (I_SYS_CLK),
            .i_nrst       (I_NRST),
            .i_cfg        (cfg_reg[g]),
            .i_remote_val (I_REMOTE_VAL[g]),
            .i_link_lost  (I_LINK_LOST[g / SGC_PINS]),
            .i_pin        (I_PIN[g]),
            .o_pin        (pin_o[g]),
            .o_pin_oe     (pin_oe[g]),
            .o_level      (level[g]),
            .o_func_in    (func_in[g])
        );
    end

    // Pin module outputs are already flops
    assign O_PIN     = pin_o;
    assign O_PIN_OE  = pin_oe;
    assign O_FUNC_IN = func_in;

endmodule

// ### pkg/sgc_pkg.sv
// Constants and types for the serializer pin configuration block
// What this block does
// - Local output value drives the pin in local GPIO output mode, and in mode 111 on link loss.
// - Output value bit 0 drives low, 1 drives high; low is default.
// - Mode low bits 00 make the pin a functional input.
// - Mode 001 is local GPIO output, 011 is GPIO input.
// - Mode 101 outputs remote value, holding last value on link loss.
// - Mode 111 outputs remote value, local value bit on link loss.
// - Port-select bit redirects config reads and writes to second port pins.
// - Pin0 mode 2:0 value 3; pin1 same next register; pin2 mode 6:4 value 7.
// - Link loss is the sticky link-lost flag of the owning port.
package sgc_pkg;

    localparam int          SGC_AW             = 8;
    localparam int          SGC_DW             = 8;
    localparam int          SGC_PINS           = 3;
    localparam int          SGC_PORTS          = 2;

    // Register offsets
    localparam logic [7:0]  SGC_OFS_PIN0       = 8'h0d;
    localparam logic [7:0]  SGC_OFS_PIN12      = 8'h0e;
    localparam logic [7:0]  SGC_OFS_PORT_SEL   = 8'h20;
    localparam logic [7:0]  SGC_OFS_PIN_LEVEL  = 8'h21;

    // Field positions
    localparam int          SGC_LO_FIELD_LSB   = 0;
    localparam int          SGC_HI_FIELD_LSB   = 4;
    localparam int          SGC_FIELD_W        = 4;
    localparam int          SGC_PORT_SEL_BIT   = 0;

    // Reset values
    localparam logic [3:0]  SGC_CFG_RST        = 4'h0;
    localparam logic        SGC_PORT_SEL_RST   = 1'b0;
    localparam logic [3:0]  SGC_REVISION_DFLT  = 4'h1;

    // Mode codes
    localparam logic [2:0]  SGC_MODE_GPIO_OUT  = 3'h1;
    localparam logic [2:0]  SGC_MODE_GPIO_IN   = 3'h3;
    localparam logic [2:0]  SGC_MODE_REM_HOLD  = 3'h5;
    localparam logic [2:0]  SGC_MODE_REM_DFLT  = 3'h7;
    localparam logic [1:0]  SGC_LOW_FUNC_IN    = 2'h0;
    localparam logic [1:0]  SGC_LOW_HIZ        = 2'h2;

    typedef struct packed {
        logic       out_val;
        logic [2:0] mode;
    } sgc_pin_cfg_s;

endpackage

// ### rtl/sgc_pin.sv
// One configurable pin: mode decode, remote hold and input synchroniser
`timescale 1ns/100ps
module sgc_pin
    import sgc_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire sgc_pin_cfg_s i_cfg,
    input  wire logic         i_remote_val,
    input  wire logic         i_link_lost,
    input  wire logic         i_pin,
    output logic              o_pin,
    output logic              o_pin_oe,
    output logic              o_level,
    output logic              o_func_in
);

    logic sync1_reg;
    logic sync2_reg;
    logic held_reg;
    logic drv_next;
    logic oe_next;

    // Pin level crosses in from outside
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // Last value received while the link was up
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            held_reg <= 1'b0;
        end else if (!i_link_lost) begin
            held_reg <= i_remote_val;
        end
    end

    always_comb begin
        drv_next = 1'b0;
        oe_next  = 1'b0;
        unique case (i_cfg.mode)
            SGC_MODE_GPIO_OUT: begin
                oe_next  = 1'b1;
                drv_next = i_cfg.out_val;
            end
            SGC_MODE_REM_HOLD: begin
                oe_next  = 1'b1;
                drv_next = i_link_lost ? held_reg : i_remote_val;
            end
            SGC_MODE_REM_DFLT: begin
                oe_next  = 1'b1;
                drv_next = i_link_lost ? i_cfg.out_val : i_remote_val;
            end
            default: begin
                // x00 functional input, x10 high impedance, 011 GPIO input
                oe_next  = 1'b0;
                drv_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_pin     <= 1'b0;
            o_pin_oe  <= 1'b0;
            o_level   <= 1'b0;
            o_func_in <= 1'b0;
        end else begin
            o_pin     <= drv_next;
            o_pin_oe  <= oe_next;
            o_level   <= sync2_reg;
            // Core sees the pin only in functional input mode
            o_func_in <= (i_cfg.mode[1:0] == SGC_LOW_FUNC_IN) && sync2_reg;
        end
    end

endmodule

// ### testbench/sgc_assertions.sv
// Port checks for the pin configuration block
`timescale 1ns/100ps
module sgc_assertions (
    input wire logic       I_SYS_CLK,
    input wire logic       I_NRST,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic       I_WR,
    input wire logic       I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic [5:0] I_REMOTE_VAL,
    input wire logic [1:0] I_LINK_LOST,
    input wire logic [5:0] O_PIN,
    input wire logic [5:0] O_PIN_OE,
    input wire logic [5:0] O_FUNC_IN
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    wire        wr0 = I_WR && I_ADDR == 8'h0d;
    logic [2:0] b;
    logic [3:0] c0;
    // Mirrors port0 pin0 only, to keep the checker small
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) {b, c0} <= 7'h0;
        else if (I_WR && I_ADDR == 8'h20) b <= I_WDATA[0] ? 3'h3 : 3'h0;
        else if (wr0 && b == 3'h0) c0 <= I_WDATA[3:0];
    end
    AST_RD: assert property (O_RDATA != 8'h0 |-> $past(I_RD)) else $error("stray rdata");
    AST_RST: assert property ($rose(I_NRST) |-> (O_PIN | O_PIN_OE | O_FUNC_IN) == 6'h0) else $error("rst");
    AST_DRV: assert property (wr0 && I_WDATA[2:0] == 3'h1 |-> ##2
        O_PIN_OE[$past(b, 2)] && O_PIN[$past(b, 2)] == $past(I_WDATA[3], 2)) else $error("drive");
    AST_OFF: assert property (wr0 && I_WDATA[1:0] != 2'h1 && I_WDATA[2:0] != 3'h7 |-> ##2
        !O_PIN_OE[$past(b, 2)]) else $error("undriven");
    AST_FI: assert property ((O_FUNC_IN & O_PIN_OE) == 6'h0) else $error("func in");
    AST_HOLD: assert property (c0[2:0] == 3'h5 && $past(c0[2:0]) == 3'h5 && I_LINK_LOST[0]
        && $past(I_LINK_LOST[0]) |=> $stable(O_PIN[0])) else $error("hold");
    AST_DFLT: assert property (c0[2:0] == 3'h7 && I_LINK_LOST[0] |=> O_PIN[0] == $past(c0[3])) else $error("dflt");
    AST_LIVE: assert property (c0[0] && c0[2] && !I_LINK_LOST[0] |=>
        O_PIN_OE[0] && O_PIN[0] == $past(I_REMOTE_VAL[0])) else $error("live");
    cover property (c0[2:0] == 3'h5 && I_LINK_LOST[0]);
    cover property (c0[2:0] == 3'h7 && I_LINK_LOST[0]);
    cover property (wr0 && b == 3'h3);
endmodule
bind sgc_top sgc_assertions u_chk (.*);

// ### testbench/sgc_remote.sv
// Behavioural remote deserializer: pin values and sticky link-lost flags
`timescale 1ns/100ps
module sgc_remote (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic [5:0] i_val,
    input  wire logic [1:0] i_drop,
    input  wire logic       i_clr,
    output logic      [5:0] o_val,
    output logic      [1:0] o_lost
);
    always_ff @(posedge i_clk) o_val <= i_val;
    // Sticky until cleared, as the status flag is
    always_ff @(posedge i_clk) o_lost <= (!i_nrst || i_clr) ? 2'h0 : (o_lost | i_drop);
endmodule

// ### testbench/sgc_top_bench.sv
// Directed bench for the pin configuration block
`timescale 1ns/100ps
module sgc_top_bench;
    import sgc_pkg::*;
    logic       clk = 0, nrst = 0, wr = 0, rd = 0, clr = 0;
    logic [7:0] addr = 0, wdat = 0, rdat;
    logic [5:0] rv = 0, pin = 6'h3f, rval, oe, opin, fin;
    logic [1:0] drop = 0, lost;
    int         n_errors = 0, samples_checked = 0;
    localparam logic [3:0] R = SGC_REVISION_DFLT;
    always #4 clk = ~clk;
    sgc_top DUT (.I_SYS_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdat), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat),
        .I_REMOTE_VAL(rval), .I_LINK_LOST(lost), .I_PIN(pin), .O_PIN(opin), .O_PIN_OE(oe), .O_FUNC_IN(fin));
    sgc_remote u_rem (.i_clk(clk), .i_nrst(nrst), .i_val(rv), .i_drop(drop), .i_clr(clr), .o_val(rval), .o_lost(lost));
    task chk(input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        {wr, addr, wdat} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_reg(input logic [7:0] a, e);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 0;
        #1 chk(rdat, e);
    endtask
    task lk(input logic [5:0] v, input logic [1:0] d, input logic c);
        @(posedge clk);
        {rv, drop, clr} <= {v, d, c};
        @(posedge clk);
        {drop, clr} <= 3'h0;
    endtask
    // Three edges cover both the output register and the input synchroniser
    task st;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task t_regs;
        rd_reg(SGC_OFS_PIN0, {R, 4'h0});
        rd_reg(SGC_OFS_PIN12, 8'h00);
        wr_reg(SGC_OFS_PIN0, 8'hf9);
        rd_reg(SGC_OFS_PIN0, {R, 4'h9});
        rd_reg(8'h33, 8'h00);
        wr_reg(SGC_OFS_PIN12, 8'h91);
        st;
        chk({oe[3:0], opin[3:0] & oe[3:0]}, 8'h75);
        rd_reg(SGC_OFS_PIN12, 8'h91);
    endtask
    task t_modes;
        for (int i = 0; i < 8; i++) begin
            wr_reg(SGC_OFS_PIN0, 8'h08 | i[7:0]);
            st;
            chk({5'h0, oe[0], opin[0] & oe[0], fin[0]},
                {5'h0, i == 1 || (i >= 5 && i[0]), i == 1, i[1:0] == 2'h0});
        end
    endtask
    task t_port;
        wr_reg(SGC_OFS_PORT_SEL, 8'h01);
        wr_reg(SGC_OFS_PIN0, 8'h09);
        st;
        chk({oe[3:0], opin[3:0] & oe[3:0]}, 8'hfc);
        rd_reg(SGC_OFS_PIN0, {R, 4'h9});
        wr_reg(SGC_OFS_PORT_SEL, 8'h00);
        rd_reg(SGC_OFS_PIN0, {R, 4'hf});
    endtask
    task t_remote;
        lk(6'h01, 2'h0, 1'b0);
        wr_reg(SGC_OFS_PIN0, 8'h05);
        st;
        chk({2'h0, opin & oe}, 8'h0d);
        lk(6'h00, 2'h1, 1'b0);
        st;
        chk({2'h0, opin & oe}, 8'h0d);
        wr_reg(SGC_OFS_PIN0, 8'h0f);
        st;
        chk({2'h0, opin & oe}, 8'h0d);
        wr_reg(SGC_OFS_PIN0, 8'h07);
        st;
        chk({2'h0, opin & oe}, 8'h0c);
        lk(6'h01, 2'h0, 1'b1);
        st;
        chk({2'h0, opin & oe}, 8'h0d);
    endtask
    task t_level;
        wr_reg(SGC_OFS_PIN12, 8'h93);
        st;
        chk({2'h0, oe}, 8'h0d);
        rd_reg(SGC_OFS_PIN_LEVEL, 8'h07);
        @(posedge clk);
        pin <= 6'h2a;
        st;
        chk({2'h0, fin}, 8'h20);
        rd_reg(SGC_OFS_PIN_LEVEL, 8'h02);
        wr_reg(SGC_OFS_PORT_SEL, 8'h01);
        rd_reg(SGC_OFS_PORT_SEL, 8'h01);
        rd_reg(SGC_OFS_PIN_LEVEL, 8'h05);
        // Mid-run reset must clear configuration and port select again
        @(posedge clk);
        nrst <= 0;
        repeat (2) @(posedge clk);
        nrst <= 1;
        st;
        chk({2'h0, oe}, 8'h00);
        chk({2'h0, fin}, 8'h2a);
        rd_reg(SGC_OFS_PORT_SEL, 8'h00);
        rd_reg(SGC_OFS_PIN0, {R, 4'h0});
    endtask
    task close_out;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1;
        t_regs;
        t_modes;
        t_port;
        t_remote;
        t_level;
        close_out;
    end
    initial begin
        #100000;
        n_errors++;
        close_out;
    end
endmodule
